// >>> logic/tcd_column_loader.sv
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - token shifts on each data clock rise
// - falling edge stores bus into selected group
// - stop internal clock after 64 clocks
// - invert input complements stored bus bits
// - stored code k selects bias level k
// - direction input sets token travel way
// - direction input sets channel write order
// - each token position enables three channels
// - left starts channel 0, right 189
// - low, mid, high fields drive 3n..3n+2
// - direction swaps cascade port input/output roles
// - load strobe high copies memory to latch
// - load strobe clears token and gating
// - decoder asserts exactly one select line
module tcd_column_loader
  import tcd_pkg::*;
#(
  parameter int GROUPS = TCD_GROUPS
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_data_clk,
  input wire logic [TCD_BUS_W-1:0] i_colour_bus,
  input wire logic i_polarity_invert,
  input wire logic i_shift_left,
  input wire logic i_load_strobe,
  input wire logic i_global_reset_n,
  input wire logic i_cascade_port_a,
  output logic o_cascade_port_a,
  output logic o_cascade_port_a_oe,
  input wire logic i_cascade_port_b,
  output logic o_cascade_port_b,
  output logic o_cascade_port_b_oe,
  output logic [3*GROUPS*TCD_CODE_W-1:0] o_column_drives,
  output logic [3*GROUPS*TCD_LEVELS-1:0] o_level_select_lines,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp
);
  localparam int OUTS = 3 * GROUPS;
  localparam int CW = $clog2(GROUPS + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(GROUPS);
  localparam logic [CW-1:0] CNT_LAST = CW'(GROUPS - 1);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  function automatic logic [TCD_LEVELS-1:0] tcd_onehot(input logic [TCD_CODE_W-1:0] code);
    tcd_onehot = 8'h01 << code;
  endfunction

  logic [TCD_SYNC_W-1:0] sync1_r, sync2_r;
  logic clk_d_r, clk_d_nxt;
  logic [GROUPS-1:0] token_r, token_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic gated_r, gated_nxt;
  logic cas_out_r, cas_out_nxt;
  logic [TCD_BUS_W-1:0] mem_r [GROUPS];
  logic [TCD_BUS_W-1:0] mem_nxt [GROUPS];
  logic [3*GROUPS*TCD_CODE_W-1:0] latch_r, latch_nxt;
  logic [OUTS*TCD_LEVELS-1:0] sel_r, sel_nxt;
  logic dph_r, dph_nxt;
  logic dwr_r, dwr_nxt;
  logic [7:0] daddr_r, daddr_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  logic clk_rise, clk_fall, left, cas_in, ls, clr, soft_clr, new_tok;
  logic [TCD_BUS_W-1:0] wdata;
  logic [TCD_BUS_W-1:0] mem_first, mem_last;
  logic [31:0] status;

  assign clk_rise = sync2_r[TCD_PIN_CLK] & ~clk_d_r;
  assign clk_fall = ~sync2_r[TCD_PIN_CLK] & clk_d_r;
  assign left = sync2_r[TCD_PIN_LEFT];
  assign cas_in = left ? sync2_r[TCD_PIN_CAS_A] : sync2_r[TCD_PIN_CAS_B];
  assign ls = sync2_r[TCD_PIN_LS];
  assign soft_clr = dph_r & dwr_r & (daddr_r == TCD_OFS_CTRL) & i_hwdata[TCD_CTRL_CLR_BIT];
  assign clr = ~sync2_r[TCD_PIN_CLR_N] | soft_clr;
  assign wdata = sync2_r[TCD_BUS_W-1:0] ^ {TCD_BUS_W{sync2_r[TCD_PIN_INV]}};
  assign new_tok = cas_in & (cnt_r == '0);
  assign mem_first = mem_r[0];
  assign mem_last = mem_r[GROUPS-1];

  always_comb begin
    status = '0;
    status[CW-1:0] = cnt_r;
    status[TCD_ST_GATED_BIT] = gated_r;
    status[TCD_ST_LEFT_BIT] = left;
    status[TCD_ST_CASOUT_BIT] = cas_out_r;
  end

  // Pin synchroniser; only the second stage is used by logic
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      sync1_r <= TCD_SYNC_RST;
      sync2_r <= TCD_SYNC_RST;
    end else begin
      sync1_r <= {i_data_clk, i_load_strobe, i_global_reset_n, i_polarity_invert, i_shift_left,
                  i_cascade_port_a, i_cascade_port_b, i_colour_bus};
      sync2_r <= sync1_r;
    end
  end

  always_comb begin
    clk_d_nxt = sync2_r[TCD_PIN_CLK];
    token_nxt = token_r;
    cnt_nxt = cnt_r;
    gated_nxt = gated_r;
    cas_out_nxt = cas_out_r;
    mem_nxt = mem_r;
    latch_nxt = latch_r;
    sel_nxt = sel_r;
    if (clr || ls) begin
      token_nxt = '0;
      cnt_nxt = '0;
      gated_nxt = 1'b0;
      cas_out_nxt = 1'b0;
    end else begin
      if (clk_rise) begin
        cas_out_nxt = 1'b0;
        if (!gated_r) begin
          if (left) begin
            token_nxt = {token_r[GROUPS-2:0], new_tok};
          end else begin
            token_nxt = {new_tok, token_r[GROUPS-1:1]};
          end
          if ((cnt_r != '0 || new_tok) && cnt_r != CNT_FULL) begin
            cnt_nxt = cnt_r + CNT_ONE;
          end
          if (cnt_r == CNT_LAST) begin
            cas_out_nxt = 1'b1;
          end
        end
      end
      if (clk_fall && !gated_r) begin
        for (int g = 0; g < GROUPS; g++) begin
          if (token_r[g]) begin
            mem_nxt[g] = wdata;
          end
        end
        if (cnt_r == CNT_FULL) begin
          gated_nxt = 1'b1;
        end
      end
    end
    if (clr) begin
      for (int g = 0; g < GROUPS; g++) begin
        mem_nxt[g] = '0;
      end
    end
    if (ls) begin
      for (int g = 0; g < GROUPS; g++) begin
        latch_nxt[g*TCD_BUS_W +: TCD_BUS_W] = mem_r[g];
      end
      for (int o = 0; o < OUTS; o++) begin
        sel_nxt[o*TCD_LEVELS +: TCD_LEVELS] = tcd_onehot(mem_r[o/3][(o%3)*TCD_CODE_W +: TCD_CODE_W]);
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      clk_d_r <= 1'b0;
      token_r <= '0;
      cnt_r <= '0;
      gated_r <= 1'b0;
      cas_out_r <= 1'b0;
      for (int g = 0; g < GROUPS; g++) begin
        mem_r[g] <= '0;
      end
      latch_r <= '0;
      for (int o = 0; o < OUTS; o++) begin
        sel_r[o*TCD_LEVELS +: TCD_LEVELS] <= 8'h01;
      end
    end else begin
      clk_d_r <= clk_d_nxt;
      token_r <= token_nxt;
      cnt_r <= cnt_nxt;
      gated_r <= gated_nxt;
      cas_out_r <= cas_out_nxt;
      mem_r <= mem_nxt;
      latch_r <= latch_nxt;
      sel_r <= sel_nxt;
    end
  end

  // AHB-Lite slave, zero wait states, read data fetched in the address phase
  always_comb begin
    dph_nxt = i_hsel & i_htrans[1] & i_hready;
    dwr_nxt = i_hwrite;
    daddr_nxt = i_haddr[7:0];
    rdata_nxt = rdata_r;
    if (i_hsel && i_htrans[1] && i_hready && !i_hwrite) begin
      rdata_nxt = (i_haddr[7:0] == TCD_OFS_STATUS) ? status : '0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      dph_r <= 1'b0;
      dwr_r <= 1'b0;
      daddr_r <= '0;
      rdata_r <= TCD_RDATA_RST;
    end else begin
      dph_r <= dph_nxt;
      dwr_r <= dwr_nxt;
      daddr_r <= daddr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_hrdata = rdata_r;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_cascade_port_a = cas_out_r;
  assign o_cascade_port_b = cas_out_r;
  assign o_cascade_port_a_oe = ~left;
  assign o_cascade_port_b_oe = left;
  assign o_column_drives = latch_r;
  assign o_level_select_lines = sel_r;

  a_token_single: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $onehot0(token_r)) else $error("more than one token stage active");
  a_select_onehot: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $onehot(sel_r[TCD_LEVELS-1:0]) && $onehot(sel_r[OUTS*TCD_LEVELS-1 -: TCD_LEVELS]))
    else $error("level select not one-hot");
  a_strobe_clears: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    ls |=> token_r == '0 && cnt_r == '0 && !gated_r) else $error("load strobe did not clear");
  a_clear_memory: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    clr |=> mem_first == '0 && mem_last == '0 && token_r == '0) else $error("clear missed memory");
  a_gate_holds: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    gated_r && !ls && !clr |=> $stable(token_r) && $stable(cnt_r) && $stable(mem_first))
    else $error("gated clock still moving");
  a_fall_capture: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    clk_fall && !gated_r && token_r[0] && !clr && !ls |=> mem_first == $past(wdata))
    else $error("group 0 capture wrong");
  a_left_shift: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    clk_rise && !gated_r && left && !clr && !ls |=> token_r[1] == $past(token_r[0]))
    else $error("left shift wrong");
  a_right_shift: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    clk_rise && !gated_r && !left && !clr && !ls |=> token_r[GROUPS-2] == $past(token_r[GROUPS-1]))
    else $error("right shift wrong");
  a_latch_copy: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    ls |=> latch_r[TCD_BUS_W-1:0] == $past(mem_first)) else $error("latch copy wrong");
  a_casc_pulse: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $rose(cas_out_r) |-> cnt_r == CNT_FULL && token_r[left ? GROUPS-1 : 0])
    else $error("cascade out at wrong time");
  a_port_roles: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_cascade_port_a_oe != o_cascade_port_b_oe && o_cascade_port_b_oe == left)
    else $error("cascade port roles wrong");

  a_count_range: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    cnt_r <= CNT_FULL) else $error("clock count beyond line length");

  a_gate_needs_full: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    gated_r |-> cnt_r == CNT_FULL) else $error("gated before line complete");

  a_token_idle_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    cnt_r == '0 |-> token_r == '0) else $error("token present while idle");

  a_token_present: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    cnt_r != '0 |-> $onehot(token_r)) else $error("token lost during line");

  a_count_step: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    clk_rise && !gated_r && !clr && !ls && cnt_r != '0 && cnt_r != CNT_FULL |=> cnt_r == $past(cnt_r) + CNT_ONE)
    else $error("clock count did not advance");

  a_token_start: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    clk_rise && new_tok && !gated_r && !clr && !ls |=> $onehot(token_r) && cnt_r == CNT_ONE)
    else $error("token not started");

  a_left_entry: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    clk_rise && new_tok && left && !gated_r && !clr && !ls |=> token_r[0])
    else $error("left line not started at group 0");

  a_right_entry: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    clk_rise && new_tok && !left && !gated_r && !clr && !ls |=> token_r[GROUPS-1])
    else $error("right line not started at last group");

  a_casc_full: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    cas_out_r |-> cnt_r == CNT_FULL) else $error("cascade out before line end");

  a_casc_fall: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    cas_out_r && clk_rise && !clr && !ls |=> !cas_out_r) else $error("cascade pulse too long");

  a_casc_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    clr || ls |=> !cas_out_r) else $error("cascade out not cleared");

  a_gate_on_fall: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    clk_fall && !gated_r && cnt_r == CNT_FULL && !clr && !ls |=> gated_r)
    else $error("clock not gated after last group");

  a_gate_stays: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    gated_r && !clr && !ls |=> gated_r) else $error("gating dropped without clear");

  a_no_early_gate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !gated_r && cnt_r != CNT_FULL |=> !gated_r) else $error("gating set early");

  a_mem_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !clk_fall && !clr |=> $stable(mem_first) && $stable(mem_last)) else $error("memory changed without fall");

  a_last_capture: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    clk_fall && !gated_r && token_r[GROUPS-1] && !clr && !ls |=> mem_last == $past(wdata))
    else $error("last group capture wrong");

  a_latch_last: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    ls |=> latch_r[3*GROUPS*TCD_CODE_W-1 -: TCD_BUS_W] == $past(mem_last)) else $error("last latch copy wrong");

  a_latch_mid: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    ls |=> latch_r[(GROUPS/2)*TCD_BUS_W +: TCD_BUS_W] == $past(mem_r[GROUPS/2])) else $error("mid latch copy wrong");

  a_latch_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !ls |=> $stable(latch_r) && $stable(sel_r)) else $error("latch changed without strobe");

  a_sel_first: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    sel_r[TCD_LEVELS-1:0] == tcd_onehot(latch_r[TCD_CODE_W-1:0])) else $error("first select mismatch");

  a_sel_last: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    sel_r[OUTS*TCD_LEVELS-1 -: TCD_LEVELS] == tcd_onehot(latch_r[OUTS*TCD_CODE_W-1 -: TCD_CODE_W]))
    else $error("last select mismatch");

  a_clear_state: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    clr |=> cnt_r == '0 && !gated_r) else $error("clear missed count or gating");
endmodule

// >>> logic/tcd_pkg.sv
package tcd_pkg;
  localparam int TCD_GROUPS = 64;
  localparam int TCD_CODE_W = 3;
  localparam int TCD_BUS_W = 9;
  localparam int TCD_LEVELS = 8;
  localparam int TCD_SYNC_W = 16;
  // Pin positions inside the synchronised pin vector
  localparam int TCD_PIN_CLK = 15;
  localparam int TCD_PIN_LS = 14;
  localparam int TCD_PIN_CLR_N = 13;
  localparam int TCD_PIN_INV = 12;
  localparam int TCD_PIN_LEFT = 11;
  localparam int TCD_PIN_CAS_A = 10;
  localparam int TCD_PIN_CAS_B = 9;
  // Register map
  localparam logic [7:0] TCD_OFS_CTRL = 8'h00;
  localparam logic [7:0] TCD_OFS_STATUS = 8'h04;
  localparam int TCD_CTRL_CLR_BIT = 0;
  localparam int TCD_ST_GATED_BIT = 7;
  localparam int TCD_ST_LEFT_BIT = 8;
  localparam int TCD_ST_CASOUT_BIT = 9;
  localparam logic [31:0] TCD_RDATA_RST = 32'h0000_0000;
  localparam logic [TCD_SYNC_W-1:0] TCD_SYNC_RST = 16'h2000;
endpackage

// >>> tb/tcd_ctrl_model.sv
`timescale 1ns/1ps
module tcd_ctrl_model
  import tcd_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic [TCD_GROUPS*TCD_BUS_W-1:0] i_words,
  output logic o_data_clk,
  output logic [TCD_BUS_W-1:0] o_colour_bus,
  output logic o_cascade_en
);
  initial begin
    o_data_clk = 1'b0;
    o_colour_bus = '0;
    o_cascade_en = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  // One line of groups plus a dummy pulse, clock high for h and low for 2h ref clocks
  task automatic send_line(input int h);
    for (int k = 0; k <= TCD_GROUPS; k++) begin
      wait_clk(h);
      if (k < TCD_GROUPS)
        o_colour_bus <= i_words[k*TCD_BUS_W +: TCD_BUS_W];
      o_cascade_en <= (k == 0);
      wait_clk(h);
      o_data_clk <= 1'b1;
      wait_clk(h);
      o_data_clk <= 1'b0;
    end
  endtask
endmodule

// >>> tb/test_tcd_column_loader.sv
`timescale 1ns/1ps
module test_tcd_column_loader;
  import tcd_pkg::*;
  logic clk, rst_n, load, clr_n, inv, left, hsel, hwrite, hready, hresp;
  logic dclk, cas, pa, pb, oa, oa_oe, ob, ob_oe;
  logic [31:0] haddr, hwdata, hrdata, rdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [TCD_BUS_W-1:0] bus;
  logic [TCD_GROUPS*TCD_BUS_W-1:0] words;
  logic [3*TCD_GROUPS*TCD_CODE_W-1:0] drives;
  logic [3*TCD_GROUPS*TCD_LEVELS-1:0] sels;
  logic [31:0] seed = 32'h0000_150D;
  int err_count, checked, cas_hi;
  assign pa = oa_oe ? oa : (left & cas);
  assign pb = ob_oe ? ob : (~left & cas);
  tcd_column_loader u_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_data_clk(dclk), .i_colour_bus(bus),
    .i_polarity_invert(inv), .i_shift_left(left), .i_load_strobe(load), .i_global_reset_n(clr_n),
    .i_cascade_port_a(pa), .o_cascade_port_a(oa), .o_cascade_port_a_oe(oa_oe),
    .i_cascade_port_b(pb), .o_cascade_port_b(ob), .o_cascade_port_b_oe(ob_oe),
    .o_column_drives(drives), .o_level_select_lines(sels), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp));
  tcd_ctrl_model u_ctrl (.i_ref_clk(clk), .i_words(words), .o_data_clk(dclk), .o_colour_bus(bus),
    .o_cascade_en(cas));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Counts cycles the downstream cascade port is driven high
  always @(posedge clk) begin
    if (left ? (ob_oe & ob) : (oa_oe & oa))
      cas_hi <= cas_hi + 1;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [2:0] exp_code(int o, logic zero);
    logic [8:0] w;
    w = words[TCD_BUS_W*(left ? o/3 : TCD_GROUPS-1-o/3) +: TCD_BUS_W] ^ {9{inv}};
    return zero ? 3'h0 : w[3*(o%3) +: 3];
  endfunction
  task chk(string name, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", name, e, g);
    end
  endtask
  task ahb(logic wr, logic [31:0] a, logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk);
    while (!hready) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge clk);
    while (!hready) @(posedge clk);
    rdata = hrdata;
  endtask
  task test_done();
    $display("Comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    test_done();
  end
  initial begin
    {rst_n, load, inv, hsel, hwrite, haddr, htrans, hwdata, words} = '0;
    {clr_n, left, hsize} = 5'h12;
    {err_count, checked, cas_hi} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int t = 0; t < 5; t++) begin
      left <= ~t[0];
      inv <= t[1];
      for (int k = 0; k < TCD_GROUPS; k++) begin
        r = xs();
        words[k*TCD_BUS_W +: TCD_BUS_W] <= (t == 3) ? 9'h1FF : r[8:0];
      end
      cas_hi = 0;
      @(posedge clk);
      u_ctrl.send_line(4 + 2 * t[0]);
      repeat (6) @(posedge clk);
      if (t == 4) begin
        ahb(1'b1, TCD_OFS_CTRL, 32'h1);
        ahb(1'b0, TCD_OFS_STATUS, 32'h0);
        chk("soft_clear", {23'h0, left, 8'h00}, rdata);
        ahb(1'b0, 32'h10, 32'h0);
        chk("unmapped", 32'h0, rdata);
        clr_n <= 1'b0;
        repeat (4) @(posedge clk);
        clr_n <= 1'b1;
      end else begin
        ahb(1'b0, TCD_OFS_STATUS, 32'h0);
        chk("status", {23'h0, left, 1'b1, 7'h40}, rdata);
        chk("cascade", 3 * (4 + 2 * t[0]), cas_hi);
      end
      load <= 1'b1;
      repeat (4) @(posedge clk);
      load <= 1'b0;
      repeat (6) @(posedge clk);
      for (int o = 0; o < 3 * TCD_GROUPS; o++) begin
        chk("drive", exp_code(o, t == 4), drives[3*o +: 3]);
        chk("select", 32'h1 << exp_code(o, t == 4), sels[8*o +: 8]);
      end
      ahb(1'b0, TCD_OFS_STATUS, 32'h0);
      chk("strobe_clear", {23'h0, left, 8'h00}, rdata);
    end
    test_done();
  end
endmodule
